// file: core_debug_control_status.v
// core debug control and status: mode select, event gating, channel, system view
//
// Notes on behaviour
// RQ1: debug reset low returns every debug register to its reset value.
// RQ2: debug reset acts without clock, so standby gating cannot block it.
// RQ3: status/control clears to zero on reset.
// RQ4: bits 15:14 pick halt mode, monitor mode, or none.
// RQ5: no debug event unless invasive debug enable is high.
// RQ6: enable changes cancel pending matches; no deadlock, no lost data.
// RQ7: channel access mode field resets to non-blocking.
// RQ8: writing zero to status/control forces all fields to reset values.
// RQ9: debugger disarms break/watch points before changing enables.
// RQ10: system reset during system-view access answers slave error.
// RQ11: debugger avoids system-view accesses while a system reset may occur; the testbench starts two accesses with a system reset requested.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "dbg_ctl_map.vh"
module core_debug_control_status #(
   parameter NUM_BP = 4,
   parameter NUM_WP = 2
) (
   // clock and resets
   input  wire              clk,
   input  wire              sys_rst,
   input  wire              debug_reset_n,
   input  wire              system_reset_n,
   // core side
   input  wire              invasive_debug_enable,
   input  wire              standby_wait_flag,
   input  wire [NUM_BP-1:0] bp_match,
   input  wire [NUM_WP-1:0] wp_match,
   input  wire              core_retired,
   input  wire              chan_core_wr,
   input  wire [31:0]       chan_core_wdata,
   input  wire              chan_core_rd,
   input  wire [31:0]       sys_rdata,
   // register port
   input  wire [3:0]        addr,
   input  wire [31:0]       wdata,
   input  wire              wr_en,
   input  wire              rd_en,
   output reg  [31:0]       rdata_ff,
   // core controls
   output reg               halt_req_ff,
   output reg               monitor_exc_ff,
   output reg               stall_core_ff,
   output reg  [31:0]       chan_core_rdata_ff,
   // system view answer
   output reg               sys_done_ff,
   output reg               sys_resp_ff
);
   reg [31:0]       sc_ff;
   reg [NUM_BP-1:0] bp_en_ff;
   reg [NUM_WP-1:0] wp_en_ff;
   reg [31:0]       tx_ff;
   reg [31:0]       rx_ff;
   reg              pend_ff;
   reg [1:0]        mode_d_ff;
   reg              en_d_ff;
   wire             dbg_rst;
   wire             busy;
   wire             done;
   wire             resp;
   wire [31:0]      srdata;
   wire [1:0]       mode;
   wire             ev_ok;
   wire             hit;
   wire             cfg_chg;
   wire             sc_wr;
   wire             sys_go;
   // access length in cycles, cut to the tracker's counter width
   localparam [31:0] SYS_ACC_CYC_W = `SYS_ACC_CYC;

   function is_wr;
      input [3:0] a;
      input [3:0] ofs;
      input       we;
      begin
         is_wr = we && (a == ofs);
      end
   endfunction

   // RQ2 asynchronous debug reset
   dbg_reset_sync u_rst (
      .clk           (clk),
      .debug_reset_n (debug_reset_n),
      .dbg_rst       (dbg_rst)
   );

   assign mode    = sc_ff[`SC_MODE_HI:`SC_MODE_LO];
   // RQ5 enable gates events
   assign ev_ok   = invasive_debug_enable && (mode != `MODE_NONE);
   assign hit     = ev_ok && ((|(bp_match & bp_en_ff)) || (|(wp_match & wp_en_ff)));
   // RQ6 enable change detect
   assign cfg_chg = (mode != mode_d_ff) || (invasive_debug_enable != en_d_ff);
   assign sc_wr   = is_wr(addr, `OFS_STATUS_CONTROL, wr_en);
   assign sys_go  = is_wr(addr, `OFS_SYS_ACCESS, wr_en) ||
                    (rd_en && addr == `OFS_SYS_ACCESS);

   sys_access_tracker #(
      .CNT_W   (4),
      .ACC_CYC (SYS_ACC_CYC_W[3:0])
   ) u_sys (
      .clk            (clk),
      .sys_rst        (sys_rst),
      .system_reset_n (system_reset_n),
      .start          (sys_go),
      .wr             (wr_en),
      .wdata          (wdata),
      .sys_rdata      (sys_rdata),
      .busy_ff        (busy),
      .done_ff        (done),
      .resp_ff        (resp),
      .rdata_ff       (srdata)
   );

   // RQ1 debug register state
   always @(posedge clk or posedge dbg_rst) begin
      if (dbg_rst) begin
         // RQ3 cleared status
         sc_ff     <= `SC_RESET;
         bp_en_ff  <= {NUM_BP{1'b0}};
         wp_en_ff  <= {NUM_WP{1'b0}};
         tx_ff     <= 32'h0000_0000;
         rx_ff     <= 32'h0000_0000;
         pend_ff   <= 1'b0;
         mode_d_ff <= `MODE_NONE;
         en_d_ff   <= 1'b0;
      end else begin
         mode_d_ff <= mode;
         en_d_ff   <= invasive_debug_enable;
         if (sc_wr) begin
            // RQ8 zero write restores reset
            if (wdata == 32'h0000_0000)
               sc_ff <= `SC_RESET;
            else
               sc_ff <= (sc_ff & ~`SC_WRITABLE) | (wdata & `SC_WRITABLE);
         end
         // hardware flags, a set beats any clear or register write
         if (hit && !pend_ff)
            sc_ff[`SC_HALTED] <= (mode == `MODE_HALT);
         if (core_retired && pend_ff)
            sc_ff[`SC_RESTARTED] <= 1'b1;
         if (chan_core_wr)
            sc_ff[`SC_TX_FULL] <= 1'b1;
         else if (rd_en && addr == `OFS_CHANNEL_TX)
            sc_ff[`SC_TX_FULL] <= 1'b0;
         if (is_wr(addr, `OFS_CHANNEL_RX, wr_en))
            sc_ff[`SC_RX_FULL] <= 1'b1;
         else if (chan_core_rd)
            sc_ff[`SC_RX_FULL] <= 1'b0;
         if (is_wr(addr, `OFS_BREAK_ENABLE, wr_en))
            bp_en_ff <= wdata[NUM_BP-1:0];
         if (is_wr(addr, `OFS_WATCH_ENABLE, wr_en))
            wp_en_ff <= wdata[NUM_WP-1:0];
         if (chan_core_wr)
            tx_ff <= chan_core_wdata;
         // RQ7 non-blocking mode drops writes into full buffer
         if (is_wr(addr, `OFS_CHANNEL_RX, wr_en) &&
             !(sc_ff[`SC_RX_FULL] && sc_ff[`SC_XMODE_HI:`SC_XMODE_LO] == `XMODE_NONBLOCK))
            rx_ff <= wdata;
         // RQ6 pending match released on change
         if (cfg_chg)
            pend_ff <= 1'b0;
         else if (hit)
            pend_ff <= 1'b1;
         else if (core_retired)
            pend_ff <= 1'b0;
      end
   end

   // core control outputs
   always @(posedge clk or posedge dbg_rst) begin
      if (dbg_rst) begin
         halt_req_ff        <= 1'b0;
         monitor_exc_ff     <= 1'b0;
         stall_core_ff      <= 1'b0;
         chan_core_rdata_ff <= 32'h0000_0000;
      end else begin
         // RQ5 events only when enabled
         halt_req_ff    <= hit && !cfg_chg && mode == `MODE_HALT;
         monitor_exc_ff <= hit && !cfg_chg && mode == `MODE_MONITOR;
         // RQ6 never stall across a change
         stall_core_ff  <= pend_ff && !cfg_chg && ev_ok &&
                           sc_ff[`SC_XMODE_HI:`SC_XMODE_LO] == `XMODE_STALL;
         chan_core_rdata_ff <= rx_ff;
      end
   end

   // register read port and system-view answer
   always @(posedge clk) begin
      if (sys_rst) begin
         rdata_ff    <= 32'h0000_0000;
         sys_done_ff <= 1'b0;
         sys_resp_ff <= `RESP_OKAY;
      end else begin
         sys_done_ff <= done;
         // RQ10 error response passed out
         sys_resp_ff <= done ? resp : sys_resp_ff;
         if (done)
            rdata_ff <= srdata;
         else if (rd_en) begin
            case (addr)
               `OFS_STATUS_CONTROL: rdata_ff <= sc_ff;
               `OFS_BREAK_ENABLE:   rdata_ff <= {{(32-NUM_BP){1'b0}}, bp_en_ff};
               `OFS_WATCH_ENABLE:   rdata_ff <= {{(32-NUM_WP){1'b0}}, wp_en_ff};
               `OFS_CORE_STATE:     rdata_ff <= {28'h0000_000, busy, ~system_reset_n,
                                                 invasive_debug_enable, standby_wait_flag};
               `OFS_CHANNEL_TX:     rdata_ff <= tx_ff;
               `OFS_CHANNEL_RX:     rdata_ff <= rx_ff;
               default:             rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // core_debug_control_status

// file: dbg_ctl_map.vh
// register map, field positions, reset values and timing counts of the debug control block
`ifndef DBG_CTL_MAP_VH
`define DBG_CTL_MAP_VH

// register offsets
`define OFS_STATUS_CONTROL  4'h0
`define OFS_BREAK_ENABLE    4'h1
`define OFS_WATCH_ENABLE    4'h2
`define OFS_CORE_STATE      4'h3
`define OFS_CHANNEL_TX      4'h4
`define OFS_CHANNEL_RX      4'h5
`define OFS_SYS_ACCESS      4'h6

// status/control fields
`define SC_MODE_HI          15
`define SC_MODE_LO          14
`define SC_XMODE_HI         21
`define SC_XMODE_LO         20
`define SC_HALTED           0
`define SC_RESTARTED        1
`define SC_RX_FULL          30
`define SC_TX_FULL          29
`define SC_WRITABLE         32'h0030_c000
`define SC_RESET            32'h0000_0000

// debug mode field values
`define MODE_NONE           2'h0
`define MODE_HALT           2'h1
`define MODE_MONITOR        2'h2

// channel access mode values
`define XMODE_NONBLOCK      2'h0
`define XMODE_STALL         2'h1
`define XMODE_FAST          2'h2

// system-view response codes
`define RESP_OKAY           1'b0
`define RESP_SLVERR         1'b1

// clock rate and least system access time
`define CLK_MHZ             250
`define SYS_ACC_NS          8
`define SYS_ACC_CYC         ((`SYS_ACC_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: dbg_reset_sync.v
// debug reset synchroniser, asserted at once, released through two flops
`timescale 1ns/1ps
module dbg_reset_sync (
   // clock
   input  wire clk,
   // raw reset
   input  wire debug_reset_n,
   // synchronised reset, active high
   output wire dbg_rst
);
   reg stage1_ff;
   reg stage2_ff;

   always @(posedge clk or negedge debug_reset_n) begin
      if (!debug_reset_n) begin
         stage1_ff <= 1'b0;
         stage2_ff <= 1'b0;
      end else begin
         stage1_ff <= 1'b1;
         stage2_ff <= stage1_ff;
      end
   end

   assign dbg_rst = ~stage2_ff;
endmodule // dbg_reset_sync

// file: sys_access_tracker.v
// system-view access tracker, reports error when a system reset hits mid-access
`timescale 1ns/1ps
module sys_access_tracker #(
   parameter CNT_W = 4,
   parameter [CNT_W-1:0] ACC_CYC = 4'h2
) (
   // clock and reset
   input  wire              clk,
   input  wire              sys_rst,
   // system reset from the system
   input  wire              system_reset_n,
   // request
   input  wire              start,
   input  wire              wr,
   input  wire [31:0]       wdata,
   input  wire [31:0]       sys_rdata,
   // answer
   output reg               busy_ff,
   output reg               done_ff,
   output reg               resp_ff,
   output reg  [31:0]       rdata_ff
);
   reg [CNT_W-1:0] cnt_ff;
   reg             hit_ff;
   reg             wr_ff;

   always @(posedge clk) begin
      if (sys_rst) begin
         busy_ff  <= 1'b0;
         done_ff  <= 1'b0;
         resp_ff  <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         cnt_ff   <= {CNT_W{1'b0}};
         hit_ff   <= 1'b0;
         wr_ff    <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (start && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff  <= ACC_CYC;
            hit_ff  <= ~system_reset_n;
            wr_ff   <= wr;
         end else if (busy_ff) begin
            // RQ10 reset seen mid-access
            if (!system_reset_n)
               hit_ff <= 1'b1;
            if (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1}) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
               // RQ10 error, no data
               resp_ff  <= (hit_ff | ~system_reset_n) ? `RESP_SLVERR : `RESP_OKAY;
               rdata_ff <= (hit_ff | ~system_reset_n | wr_ff) ? wdata & 32'h0000_0000 : sys_rdata;
            end
            cnt_ff <= cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // sys_access_tracker

// file: sys_side_model.sv
// system side model: system reset source and system read data
`timescale 1ns/1ps
module sys_side_model #(
   parameter [31:0] WORD = 32'h5a5a_0f0f
) (
   // clock
   input  wire        clk,
   // reset request from the bench
   input  wire        rst_req,
   // system side
   output reg         system_reset_n,
   output wire [31:0] sys_rdata
);
   initial system_reset_n = 1'b1;
   always @(posedge clk) begin
      system_reset_n <= !rst_req;
   end
   // no valid answer while in reset
   assign sys_rdata = system_reset_n ? WORD : ~WORD;
endmodule // sys_side_model

// file: dbg_ctl_checker_asserts.sv
// assertion checker for the debug control block
`timescale 1ns/1ps
`include "dbg_ctl_map.vh"
module dbg_ctl_checker (
   // clock and resets
   input wire        clk,
   input wire        sys_rst,
   input wire        debug_reset_n,
   input wire        system_reset_n,
   // core side
   input wire        invasive_debug_enable,
   input wire        standby_wait_flag,
   // register port
   input wire [3:0]  addr,
   input wire [31:0] wdata,
   input wire        wr_en,
   input wire        rd_en,
   // outputs
   input wire [31:0] rdata_ff,
   input wire        halt_req_ff,
   input wire        monitor_exc_ff,
   input wire        stall_core_ff,
   input wire [31:0] chan_core_rdata_ff,
   input wire        sys_done_ff,
   input wire        sys_resp_ff
);
   reg  [1:0] mode_ff;
   reg  [1:0] xmode_ff;
   wire       sys_go = (wr_en || rd_en) && addr == `OFS_SYS_ACCESS;
   // mirror of writable status fields
   always @(posedge clk or negedge debug_reset_n) begin
      if (!debug_reset_n) begin
         mode_ff  <= `MODE_NONE;
         xmode_ff <= `XMODE_NONBLOCK;
      end else if (wr_en && addr == `OFS_STATUS_CONTROL) begin
         mode_ff  <= wdata[`SC_MODE_HI:`SC_MODE_LO];
         xmode_ff <= wdata[`SC_XMODE_HI:`SC_XMODE_LO];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst || !debug_reset_n);
   property p_rst_clr;
      disable iff (sys_rst) !debug_reset_n |-> !halt_req_ff && !monitor_exc_ff && !stall_core_ff;
   endproperty
   a_rst_clr: assert property (p_rst_clr)
      else $error("core outputs active in debug reset");
   property p_stby;
      disable iff (sys_rst) !debug_reset_n && standby_wait_flag |-> chan_core_rdata_ff == 32'h0;
   endproperty
   a_stby: assert property (p_stby)
      else $error("channel word kept in standby reset");
   property p_mode_rd;
      rd_en && addr == `OFS_STATUS_CONTROL |=> rdata_ff[15:14] == $past(mode_ff);
   endproperty
   a_mode_rd: assert property (p_mode_rd)
      else $error("mode field read wrong");
   property p_ev_mode;
      (halt_req_ff || monitor_exc_ff) |-> $past(mode_ff) == (halt_req_ff ? `MODE_HALT : `MODE_MONITOR);
   endproperty
   a_ev_mode: assert property (p_ev_mode)
      else $error("event kind does not match mode");
   property p_gate;
      (halt_req_ff || monitor_exc_ff) |-> $past(invasive_debug_enable);
   endproperty
   a_gate: assert property (p_gate)
      else $error("event without debug enable");
   property p_chg;
      $changed(invasive_debug_enable) |=> !halt_req_ff && !monitor_exc_ff;
   endproperty
   a_chg: assert property (p_chg)
      else $error("event in cycle of enable change");
   property p_xmode;
      rd_en && addr == `OFS_STATUS_CONTROL |=> rdata_ff[21:20] == $past(xmode_ff);
   endproperty
   a_xmode: assert property (p_xmode)
      else $error("access mode field read wrong");
   property p_sys_err;
      sys_go ##1 !system_reset_n |-> ##3 (sys_done_ff && sys_resp_ff);
   endproperty
   a_sys_err: assert property (p_sys_err)
      else $error("no error answer after system reset");
   property p_sys_ok;
      sys_go && system_reset_n ##1 system_reset_n [*2] |-> ##2 (sys_done_ff && !sys_resp_ff);
   endproperty
   a_sys_ok: assert property (p_sys_ok)
      else $error("system access not answered okay");
endmodule // dbg_ctl_checker
bind core_debug_control_status dbg_ctl_checker u_chk (
   .clk                   (clk),
   .sys_rst               (sys_rst),
   .debug_reset_n         (debug_reset_n),
   .system_reset_n        (system_reset_n),
   .invasive_debug_enable (invasive_debug_enable),
   .standby_wait_flag     (standby_wait_flag),
   .addr                  (addr),
   .wdata                 (wdata),
   .wr_en                 (wr_en),
   .rd_en                 (rd_en),
   .rdata_ff              (rdata_ff),
   .halt_req_ff           (halt_req_ff),
   .monitor_exc_ff        (monitor_exc_ff),
   .stall_core_ff         (stall_core_ff),
   .chan_core_rdata_ff    (chan_core_rdata_ff),
   .sys_done_ff           (sys_done_ff),
   .sys_resp_ff           (sys_resp_ff)
);

// file: tb.sv
// testbench for the debug control block
`timescale 1ns/1ps
`include "dbg_ctl_map.vh"
module tb;
   localparam [31:0] WORD = 32'h5a5a_0f0f;
   reg         clk, clk_run, sys_rst, debug_reset_n, rst_req;
   reg         invasive_debug_enable, standby_wait_flag, core_retired;
   reg  [3:0]  bp_match, addr;
   reg  [1:0]  wp_match;
   reg  [31:0] wdata, d;
   reg         wr_en, rd_en, seen_h, seen_m, seen_s;
   wire        chan_core_wr = 1'b0;
   wire        chan_core_rd = 1'b0;
   wire [31:0] chan_core_wdata = 32'h0;
   wire [31:0] sys_rdata, rdata_ff, chan_core_rdata_ff;
   wire        system_reset_n, halt_req_ff, monitor_exc_ff, stall_core_ff, sys_done_ff, sys_resp_ff;
   integer     err_count, n_checks, i;
   core_debug_control_status uut (
      .clk                   (clk),
      .sys_rst               (sys_rst),
      .debug_reset_n         (debug_reset_n),
      .system_reset_n        (system_reset_n),
      .invasive_debug_enable (invasive_debug_enable),
      .standby_wait_flag     (standby_wait_flag),
      .bp_match              (bp_match),
      .wp_match              (wp_match),
      .core_retired          (core_retired),
      .chan_core_wr          (chan_core_wr),
      .chan_core_wdata       (chan_core_wdata),
      .chan_core_rd          (chan_core_rd),
      .sys_rdata             (sys_rdata),
      .addr                  (addr),
      .wdata                 (wdata),
      .wr_en                 (wr_en),
      .rd_en                 (rd_en),
      .rdata_ff              (rdata_ff),
      .halt_req_ff           (halt_req_ff),
      .monitor_exc_ff        (monitor_exc_ff),
      .stall_core_ff         (stall_core_ff),
      .chan_core_rdata_ff    (chan_core_rdata_ff),
      .sys_done_ff           (sys_done_ff),
      .sys_resp_ff           (sys_resp_ff)
   );
   sys_side_model #(.WORD(WORD)) sys_m (.clk(clk), .rst_req(rst_req), .system_reset_n(system_reset_n),
      .sys_rdata(sys_rdata));
   initial begin
      clk = 1'b0;
      forever #2 if (clk_run) clk = ~clk;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [31:0] v);
      begin
         addr <= a;
         wdata <= v;
         wr_en <= 1'b1;
         @(posedge clk);
         wr_en <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rd(input [3:0] a, input [31:0] e);
      begin
         addr <= a;
         rd_en <= 1'b1;
         @(posedge clk);
         rd_en <= 1'b0;
         #1;
         chk(rdata_ff, e);
         @(posedge clk);
      end
   endtask
   // set modes and enable, arm, hold matches, record events, disarm
   task ev(input [1:0] m, input [1:0] x, input en, input eh, input em, input es);
      begin
         wr(`OFS_STATUS_CONTROL, 32'h0);
         wr(`OFS_STATUS_CONTROL, {10'h0, x, 4'h0, m, 14'h0});
         invasive_debug_enable <= en;
         @(posedge clk);
         wr(`OFS_BREAK_ENABLE, 32'h1);
         bp_match <= 4'h1;
         wp_match <= 2'h1;
         core_retired <= 1'b1;
         seen_h = 1'b0;
         seen_m = 1'b0;
         seen_s = 1'b0;
         repeat (8) begin
            @(posedge clk);
            #1;
            seen_h = seen_h | halt_req_ff;
            seen_m = seen_m | monitor_exc_ff;
            seen_s = seen_s | stall_core_ff;
         end
         @(posedge clk);
         bp_match <= 4'h0;
         wp_match <= 2'h0;
         core_retired <= 1'b0;
         repeat (4) @(posedge clk);
         // breakpoints inactive before the next mode or enable change
         wr(`OFS_BREAK_ENABLE, 32'h0);
         chk(seen_h, eh);
         chk(seen_m, em);
         chk(seen_s, es);
      end
   endtask
   task sys_acc(input w, input r);
      begin
         addr <= `OFS_SYS_ACCESS;
         wdata <= WORD;
         wr_en <= w;
         rd_en <= !w;
         rst_req <= r;
         @(posedge clk);
         wr_en <= 1'b0;
         rd_en <= 1'b0;
         rst_req <= 1'b0;
         for (i = 0; i < 8 && sys_done_ff !== 1'b1; i = i + 1) begin
            @(posedge clk);
            #1;
         end
         chk(sys_done_ff, 1'b1);
         chk(sys_resp_ff, r);
         if (!w && !r) chk(rdata_ff, WORD);
         @(posedge clk);
      end
   endtask
   task final_report;
      begin
         $display("checks=%0d errors=%0d", n_checks, err_count);
         if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      #20000;
      err_count = err_count + 1;
      final_report;
   end
   initial begin
      {clk_run, sys_rst, standby_wait_flag} = 3'h7;
      {debug_reset_n, rst_req, invasive_debug_enable, core_retired, wr_en, rd_en} = 6'h0;
      {bp_match, wp_match, addr, wdata} = 42'h0;
      err_count = 0;
      n_checks = 0;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      debug_reset_n <= 1'b1;
      standby_wait_flag <= 1'b0;
      repeat (4) @(posedge clk);
      rd(`OFS_STATUS_CONTROL, `SC_RESET);
      rd(4'hf, 32'h0);
      for (d = 0; d < 4; d = d + 1) begin
         wr(`OFS_STATUS_CONTROL, (d << 14) | ((d % 3) << 20) | 32'hff00_0003);
         rd(`OFS_STATUS_CONTROL, ((d << 14) | ((d % 3) << 20)) & `SC_WRITABLE);
      end
      wr(`OFS_STATUS_CONTROL, 32'h0);
      rd(`OFS_STATUS_CONTROL, `SC_RESET);
      ev(`MODE_HALT, `XMODE_NONBLOCK, 1'b0, 1'b0, 1'b0, 1'b0);
      ev(`MODE_HALT, `XMODE_STALL, 1'b1, 1'b1, 1'b0, 1'b1);
      ev(`MODE_MONITOR, `XMODE_NONBLOCK, 1'b1, 1'b0, 1'b1, 1'b0);
      ev(`MODE_NONE, `XMODE_STALL, 1'b1, 1'b0, 1'b0, 1'b0);
      ev(2'h3, `XMODE_NONBLOCK, 1'b1, 1'b0, 1'b0, 1'b0);
      wr(`OFS_STATUS_CONTROL, 32'h0020_8000);
      wr(`OFS_BREAK_ENABLE, 32'hf);
      wr(`OFS_WATCH_ENABLE, 32'h3);
      standby_wait_flag <= 1'b1;
      @(posedge clk);
      // debug reset pulse with the clock gated off
      clk_run = 1'b0;
      #20 debug_reset_n = 1'b0;
      #20 debug_reset_n = 1'b1;
      #20 clk_run = 1'b1;
      repeat (4) @(posedge clk);
      standby_wait_flag <= 1'b0;
      rd(`OFS_STATUS_CONTROL, `SC_RESET);
      rd(`OFS_BREAK_ENABLE, 32'h0);
      rd(`OFS_WATCH_ENABLE, 32'h0);
      // access mode back to non-blocking: second word into full buffer dropped
      wr(`OFS_CHANNEL_RX, 32'h1111_2222);
      wr(`OFS_CHANNEL_RX, 32'h3333_4444);
      rd(`OFS_CHANNEL_RX, 32'h1111_2222);
      chk(chan_core_rdata_ff, 32'h1111_2222);
      sys_acc(1'b0, 1'b0);
      sys_acc(1'b1, 1'b0);
      sys_acc(1'b0, 1'b1);
      sys_acc(1'b1, 1'b1);
      final_report;
   end
endmodule // tb
